// ---- uart_cfg.svh ----
// timing and field constants of the asynchronous serial core
// How it works
// - eight data bits per character, least significant bit first on the line
// - low start bit opens, one or two high stop bits close each character
// - optional parity bit sent and checked, even or odd as selected
// - transmitter and receiver run apart but share rate and format
// - a 16-bit divider sets bit timing, or runs as a plain timer
// - holding-empty flag is 1 while the transmit register can take a byte
// - a written byte moves to the shifter and is sent without help
// - byte-available flag is 1 while a received byte waits unread
// - transmit interrupt stands while the transmit register is empty and transmit is enabled
// - in multinode mode the ninth bit marks address (1) or data (0)
// - parity is used only while multinode mode is off
// - flow gate enable decides whether the clear-to-send input holds transmit
// - transmit and receive each have an enable of their own
// - receiver flags framing, parity, overrun and break conditions
// - separate interrupt requests for transmitter and receiver
// - a driver enable output steers an external transceiver while sending
// - selectable 9-bit multinode mode with three receive interrupt schemes
// - ninth bit sits right after the data bits and before the stop bits
// - clear-to-send sampled one clock before each character; a started one finishes
// - scheme 01 all addresses, 10 matched address and data, 11 matched data only
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define UART_OS_LAST    4'hF
`define UART_OS_HALF    4'h7
`define UART_BITS_LAST  3'h7
`define UART_FIFO_DEPTH 32
`define UART_DIV_WIDTH  16
`endif

// ---- uart_pkg.sv ----
// state and mode types of the asynchronous serial core
package uart_pkg;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h2,
    TX_NINTH = 3'h3,
    TX_STOP  = 3'h4
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h2,
    RX_NINTH = 3'h3,
    RX_STOP  = 3'h4
  } rx_state_t;
  typedef enum logic [1:0] {
    MN_EVERY      = 2'h0,
    MN_ADDR_ALL   = 2'h1,
    MN_MATCH_ALL  = 2'h2,
    MN_MATCH_DATA = 2'h3
  } mn_scheme_t;
endpackage

// ---- rate_divider.sv ----
// programmable rate divider producing a one-cycle tick
`timescale 1ns/1ns
`default_nettype none
module rate_divider #(
  parameter int W = 16
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] divisor_i,
  output logic              tick_o
);
  logic [W-1:0] cnt_q;
  // zero and one both mean divide by one
  wire at_end = (cnt_q <= {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= at_end ? divisor_i : cnt_q - 1'b1;
      tick_o <= at_end;
    end
  end

  a_tick_spacing: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tick_o && divisor_i > 2 && $stable(divisor_i) |=> !tick_o)
    else $error("divider ticked twice in a row");
endmodule
`default_nettype wire

// ---- sync_fifo.sv ----
// synchronous flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // filling side
  input  wire logic         wr_valid_i,
  output logic              wr_ready_o,
  input  wire logic [W-1:0] wr_data_i,
  // draining side
  output logic              rd_valid_o,
  input  wire logic         rd_ready_i,
  output logic [W-1:0]      rd_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q;
  wire do_wr = wr_valid_i & wr_ready_o;
  wire do_rd = rd_ready_i & rd_valid_o;
  wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
  assign rd_data_o = mem_q[rp_q];

  always_ff @(posedge ref_clk_i) begin
    if (do_wr) begin
      mem_q[wp_q] <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q       <= '0;
      rp_q       <= '0;
      cnt_q      <= '0;
      wr_ready_o <= 1'b1;
      rd_valid_o <= 1'b0;
    end else begin
      wp_q       <= do_wr ? wp_q + 1'b1 : wp_q;
      rp_q       <= do_rd ? rp_q + 1'b1 : rp_q;
      cnt_q      <= cnt_d;
      wr_ready_o <= (cnt_d != D[AW:0]);
      rd_valid_o <= (cnt_d != '0);
    end
  end

  a_fifo_bounds: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (cnt_q == D[AW:0]) |-> !wr_ready_o && rd_valid_o)
    else $error("fifo full but flags disagree");
endmodule
`default_nettype wire

// ---- async_serial_uart_core.sv ----
// full-duplex asynchronous serial transceiver with multinode support
`timescale 1ns/1ns
`default_nettype none
`include "uart_cfg.svh"
module async_serial_uart_core #(
  parameter int DIV_W      = `UART_DIV_WIDTH,
  parameter int FIFO_DEPTH = `UART_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // configuration
  input  wire logic [DIV_W-1:0] bit_rate_divider_i,
  input  wire logic             timer_mode_i,
  input  wire logic             tx_enable_i,
  input  wire logic             rx_enable_i,
  input  wire logic             parity_on_i,
  input  wire logic             parity_odd_i,
  input  wire logic             two_stop_i,
  input  wire logic             flow_gate_enable_i,
  input  wire logic             multinode_enable_i,
  input  wire logic [1:0]       multinode_irq_scheme_i,
  input  wire logic             ninth_bit_to_send_i,
  input  wire logic [7:0]       node_address_i,
  // transmit data
  input  wire logic [7:0]       tx_data_i,
  input  wire logic             tx_write_i,
  output logic                  tx_holding_empty_o,
  // receive data
  output logic [7:0]            rx_data_o,
  output logic                  rx_ninth_bit_o,
  output logic                  rx_new_frame_o,
  output logic                  rx_byte_available_o,
  input  wire logic             rx_read_i,
  // status and requests
  input  wire logic             err_clear_i,
  output logic                  framing_err_o,
  output logic                  parity_err_o,
  output logic                  overrun_err_o,
  output logic                  break_det_o,
  output logic                  tx_irq_o,
  output logic                  rx_irq_o,
  output logic                  timer_expired_o,
  // serial pins
  input  wire logic             rxd_i,
  input  wire logic             cts_n_i,
  output logic                  txd_o,
  output logic                  driver_enable_out_o
);
  logic tick_w;

  rate_divider #(.W(DIV_W)) u_div (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .divisor_i (bit_rate_divider_i),
    .tick_o    (tick_w)
  );

  // divider feeds either the serial logic or the timer, never both
  wire os_tick  = tick_w & ~timer_mode_i;
  wire ninth_on = multinode_enable_i | parity_on_i;

  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = odd ^ (^d);
  endfunction

  // ---------------- transmitter ----------------
  uart_pkg::tx_state_t tx_st_q, tx_st_d;
  logic [7:0] hold_q, tx_sh_q;
  logic       hold_full_q, hold_ninth_q, tx_ninth_q, cts_q;
  logic [3:0] tx_os_q;
  logic [2:0] tx_bit_q;

  wire tx_idle    = (tx_st_q == uart_pkg::TX_IDLE);
  wire tx_bit_end = os_tick & (tx_os_q == `UART_OS_LAST);
  // cts_q is the pin one clock before the start decision
  wire cts_ok     = ~flow_gate_enable_i | ~cts_q;
  wire tx_ready   = hold_full_q & tx_enable_i & cts_ok;
  wire tx_go      = tx_idle & tx_ready;
  wire tx_load    = tx_write_i & ~hold_full_q;
  wire hold_full_d = tx_load | (hold_full_q & ~tx_go);
  wire tx_ninth_v = multinode_enable_i ? hold_ninth_q
                                       : par_of(hold_q, parity_odd_i);
  wire tx_last_stop = ~two_stop_i | tx_bit_q[0];

  always_comb begin
    tx_st_d = tx_st_q;
    case (tx_st_q)
      uart_pkg::TX_IDLE:  if (tx_go) tx_st_d = uart_pkg::TX_START;
      uart_pkg::TX_START: if (tx_bit_end) tx_st_d = uart_pkg::TX_DATA;
      uart_pkg::TX_DATA: begin
        if (tx_bit_end && tx_bit_q == `UART_BITS_LAST) begin
          tx_st_d = ninth_on ? uart_pkg::TX_NINTH
                             : uart_pkg::TX_STOP;
        end
      end
      uart_pkg::TX_NINTH: if (tx_bit_end) tx_st_d = uart_pkg::TX_STOP;
      uart_pkg::TX_STOP: begin
        if (tx_bit_end && tx_last_stop) tx_st_d = uart_pkg::TX_IDLE;
      end
      default:            tx_st_d = uart_pkg::TX_IDLE;
    endcase
  end

  logic txd_d;
  always_comb begin
    case (tx_st_q)
      uart_pkg::TX_START: txd_d = 1'b0;
      uart_pkg::TX_DATA:  txd_d = tx_sh_q[0];
      uart_pkg::TX_NINTH: txd_d = tx_ninth_q;
      default:            txd_d = 1'b1;
    endcase
  end

  // txd lags the state by a cycle, so hold the driver through that cycle;
  // it also stays on across back-to-back characters
  wire de_d = (tx_st_d != uart_pkg::TX_IDLE) | ~tx_idle
              | (hold_full_d & tx_enable_i & cts_ok);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_q      <= uart_pkg::TX_IDLE;
      hold_q       <= 8'h00;
      hold_full_q  <= 1'b0;
      hold_ninth_q <= 1'b0;
      tx_sh_q      <= 8'h00;
      tx_ninth_q   <= 1'b0;
      tx_os_q      <= 4'h0;
      tx_bit_q     <= 3'h0;
      cts_q        <= 1'b1;
    end else begin
      tx_st_q     <= tx_st_d;
      hold_full_q <= hold_full_d;
      cts_q       <= cts_n_i;
      if (tx_load) begin
        hold_q       <= tx_data_i;
        hold_ninth_q <= ninth_bit_to_send_i;
      end
      if (tx_go) begin
        tx_sh_q    <= hold_q;
        tx_ninth_q <= tx_ninth_v;
        tx_os_q    <= 4'h0;
      end else if (!tx_idle && os_tick) begin
        tx_os_q <= tx_os_q + 4'h1;
      end
      if (tx_bit_end && tx_st_q == uart_pkg::TX_DATA) begin
        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
      end
      tx_bit_q <= (tx_st_d != tx_st_q) ? 3'h0
                : tx_bit_end ? tx_bit_q + 3'h1 : tx_bit_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txd_o               <= 1'b1;
      driver_enable_out_o <= 1'b0;
      tx_holding_empty_o  <= 1'b1;
      tx_irq_o            <= 1'b0;
      timer_expired_o     <= 1'b0;
    end else begin
      txd_o               <= txd_d;
      driver_enable_out_o <= de_d;
      tx_holding_empty_o  <= ~hold_full_d;
      tx_irq_o            <= ~hold_full_d & tx_enable_i;
      timer_expired_o     <= tick_w & timer_mode_i;
    end
  end

  // ---------------- receiver ----------------
  uart_pkg::rx_state_t rx_st_q, rx_st_d;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_os_q;
  logic [2:0] rx_bit_q;
  logic       rx_prev_q, rx_ninth_q, frame_match_q, new_pend_q;
  logic       fifo_wr_ready;

  wire rx_fall    = rx_prev_q & ~rxd_i;
  wire rx_half    = os_tick & (rx_os_q == `UART_OS_HALF);
  wire rx_bit_end = os_tick & (rx_os_q == `UART_OS_LAST);
  wire rx_done    = (rx_st_q == uart_pkg::RX_STOP) & rx_bit_end;
  wire fr_err     = rx_done & ~rxd_i;
  wire brk        = fr_err & (rx_sh_q == 8'h00)
                    & ~(ninth_on & rx_ninth_q);
  wire par_err    = rx_done & parity_on_i & ~multinode_enable_i
                    & (rx_ninth_q != par_of(rx_sh_q, parity_odd_i));
  wire is_addr    = multinode_enable_i & rx_ninth_q;
  wire addr_hit   = (rx_sh_q == node_address_i);

  // which received characters reach software
  wire [1:0] scheme = multinode_enable_i ? multinode_irq_scheme_i : 2'h0;
  logic keep;
  always_comb begin
    case (uart_pkg::mn_scheme_t'(scheme))
      uart_pkg::MN_EVERY:      keep = 1'b1;
      uart_pkg::MN_ADDR_ALL:   keep = is_addr;
      uart_pkg::MN_MATCH_ALL:  keep = is_addr ? addr_hit : frame_match_q;
      uart_pkg::MN_MATCH_DATA: keep = ~is_addr & frame_match_q;
      default:                 keep = 1'b1;
    endcase
  end

  // a break character is flagged, not queued
  wire push    = rx_done & keep & ~brk;
  wire overrun = push & ~fifo_wr_ready;
  wire new_frm = new_pend_q & ~is_addr & multinode_enable_i;

  always_comb begin
    rx_st_d = rx_st_q;
    case (rx_st_q)
      uart_pkg::RX_IDLE: begin
        if (rx_enable_i && rx_fall) rx_st_d = uart_pkg::RX_START;
      end
      uart_pkg::RX_START: begin
        if (rx_half) begin
          rx_st_d = rxd_i ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
        end
      end
      uart_pkg::RX_DATA: begin
        if (rx_bit_end && rx_bit_q == `UART_BITS_LAST) begin
          rx_st_d = ninth_on ? uart_pkg::RX_NINTH : uart_pkg::RX_STOP;
        end
      end
      uart_pkg::RX_NINTH: if (rx_bit_end) rx_st_d = uart_pkg::RX_STOP;
      uart_pkg::RX_STOP:  if (rx_bit_end) rx_st_d = uart_pkg::RX_IDLE;
      default:            rx_st_d = uart_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st_q       <= uart_pkg::RX_IDLE;
      rx_sh_q       <= 8'h00;
      rx_os_q       <= 4'h0;
      rx_bit_q      <= 3'h0;
      rx_prev_q     <= 1'b1;
      rx_ninth_q    <= 1'b0;
      frame_match_q <= 1'b0;
      new_pend_q    <= 1'b0;
    end else begin
      rx_st_q   <= rx_st_d;
      rx_prev_q <= rxd_i;
      // restart at the start-bit centre so later samples hit bit centres
      if (rx_st_q == uart_pkg::RX_IDLE || rx_half && rx_st_q ==
          uart_pkg::RX_START) begin
        rx_os_q <= 4'h0;
      end else if (os_tick) begin
        rx_os_q <= rx_os_q + 4'h1;
      end
      if (rx_bit_end && rx_st_q == uart_pkg::RX_DATA) begin
        rx_sh_q <= {rxd_i, rx_sh_q[7:1]};
      end
      if (rx_bit_end && rx_st_q == uart_pkg::RX_NINTH) begin
        rx_ninth_q <= rxd_i;
      end else if (rx_st_q == uart_pkg::RX_IDLE) begin
        rx_ninth_q <= 1'b0;
      end
      rx_bit_q <= (rx_st_d != rx_st_q) ? 3'h0
                : rx_bit_end ? rx_bit_q + 3'h1 : rx_bit_q;
      if (rx_done && is_addr) begin
        frame_match_q <= addr_hit;
        new_pend_q    <= addr_hit;
      end else if (push && new_frm && fifo_wr_ready) begin
        new_pend_q <= 1'b0;
      end
    end
  end

  // sticky error flags: a new event beats a simultaneous clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      framing_err_o <= 1'b0;
      parity_err_o  <= 1'b0;
      overrun_err_o <= 1'b0;
      break_det_o   <= 1'b0;
      rx_irq_o      <= 1'b0;
    end else begin
      framing_err_o <= fr_err | (framing_err_o & ~err_clear_i);
      parity_err_o  <= par_err | (parity_err_o & ~err_clear_i);
      overrun_err_o <= overrun | (overrun_err_o & ~err_clear_i);
      break_det_o   <= brk | (break_det_o & ~err_clear_i);
      rx_irq_o      <= rx_byte_available_o | framing_err_o | parity_err_o
                       | overrun_err_o | break_det_o;
    end
  end

  sync_fifo #(.W(10), .D(FIFO_DEPTH)) u_rx_fifo (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_valid_i (push),
    .wr_ready_o (fifo_wr_ready),
    .wr_data_i  ({new_frm, rx_ninth_q, rx_sh_q}),
    .rd_valid_o (rx_byte_available_o),
    .rd_ready_i (rx_read_i),
    .rd_data_o  ({rx_new_frame_o, rx_ninth_bit_o, rx_data_o})
  );

  // ---------------- checks ----------------
  a_start_bit_low: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_st_q == uart_pkg::TX_START |=> !txd_o)
    else $error("start bit not low");
  a_stop_bit_high: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_st_q == uart_pkg::TX_STOP |=> txd_o)
    else $error("stop bit not high");
  a_data_lsb_first: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_st_q == uart_pkg::TX_DATA |=> txd_o == $past(tx_sh_q[0]))
    else $error("data bit order wrong");
  a_even_parity: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_go && parity_on_i && !multinode_enable_i && !parity_odd_i
    |=> !(^{tx_sh_q, tx_ninth_q}))
    else $error("even parity wrong");
  a_ninth_addr_bit: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_go && multinode_enable_i |=> tx_ninth_q == $past(hold_ninth_q))
    else $error("ninth bit not taken from setting");
  a_cts_holds: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_idle && flow_gate_enable_i && cts_q |=> tx_st_q == uart_pkg::TX_IDLE)
    else $error("started while clear-to-send deasserted");
  a_hold_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_holding_empty_o == !hold_full_q)
    else $error("holding-empty flag wrong");
  a_hold_taken: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_write_i && tx_holding_empty_o |=> !tx_holding_empty_o)
    else $error("accepted byte did not fill holding register");
  a_tx_irq_empty: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_holding_empty_o && tx_enable_i && !tx_write_i |=> tx_irq_o)
    else $error("transmit request missing while empty");
  a_de_covers_tx: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !tx_idle |-> driver_enable_out_o)
    else $error("driver enable low during character");
  a_de_last_stop: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !tx_idle |=> driver_enable_out_o)
    else $error("driver enable dropped before stop bit ended");
  a_framing_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    fr_err |=> framing_err_o [*2])
    else $error("framing error not held");
  a_overrun_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    push && !fifo_wr_ready |=> overrun_err_o)
    else $error("overrun not flagged");
endmodule
`default_nettype wire

// ---- uart_remote_model.sv ----
// remote serial node: drives the receive line, captures the transmit line
`timescale 1ns/1ns
`default_nettype none
module uart_remote_model #(
  parameter int BT = 16
) (
  // clock
  input  wire logic ref_clk_i,
  // serial lines
  input  wire logic txd_i,
  input  wire logic de_i,
  output logic      rxd_o,
  output logic      cts_n_o
);
  // line has a pull-up, so idle is mark
  initial begin
    rxd_o   = 1'b1;
    cts_n_o = 1'b0;
  end
  // nb bits after start, lsb first; stop_v low forges framing or break
  task automatic send(input logic [8:0] v, input int nb, input int ns,
                      input logic stop_v);
    rxd_o = 1'b0;
    repeat (BT) @(negedge ref_clk_i);
    for (int i = 0; i < nb; i++) begin
      rxd_o = v[i];
      repeat (BT) @(negedge ref_clk_i);
    end
    rxd_o = stop_v;
    repeat (BT * ns) @(negedge ref_clk_i);
    rxd_o = 1'b1;
    // one idle clock so a following start never lands in the same step
    @(negedge ref_clk_i);
  endtask
  // samples at bit centres; ok also needs the driver enable up at every sample
  task automatic recv(input int nb, input int ns, output logic [8:0] v,
                      output logic ok);
    v = '0;
    @(negedge txd_i);
    repeat (BT / 2) @(negedge ref_clk_i);
    ok = (txd_i === 1'b0) && (de_i === 1'b1);
    for (int i = 0; i < nb + ns; i++) begin
      repeat (BT) @(negedge ref_clk_i);
      if (i < nb)
        v[i] = txd_i;
      else
        ok = ok && (txd_i === 1'b1);
      ok = ok && (de_i === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb_async_serial_uart_core.sv ----
// self-checking bench for the asynchronous serial core
`timescale 1ns/1ns
`default_nettype none
module tb_async_serial_uart_core;
  logic        ref_clk_i, rst_n_i, timer_mode, tx_en, rx_en, par_on;
  logic        par_odd, two_stop, flow_en, mn_en, ninth, tx_write;
  logic        rx_read, err_clear, nv, ok;
  logic [15:0] divisor;
  logic [1:0]  scheme;
  logic [7:0]  node_addr, tx_data, d;
  logic [8:0]  got;
  wire logic   tx_empty, rx_ninth, rx_nf, rx_avail, fe, pe, oe, brk;
  wire logic   tx_irq, rx_irq, tmr_exp, txd, rxd, cts_n, de;
  wire logic [7:0] rx_data;
  int          failures, tests_run, nb, ns, n;
  int          cnt_tab [4] = '{4, 2, 2, 1};
  logic [7:0]  dtab [5] = '{8'hA5, 8'h3C, 8'h96, 8'h5A, 8'h01};

  async_serial_uart_core dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .bit_rate_divider_i(divisor), .timer_mode_i(timer_mode),
    .tx_enable_i(tx_en), .rx_enable_i(rx_en), .parity_on_i(par_on),
    .parity_odd_i(par_odd), .two_stop_i(two_stop),
    .flow_gate_enable_i(flow_en), .multinode_enable_i(mn_en),
    .multinode_irq_scheme_i(scheme), .ninth_bit_to_send_i(ninth),
    .node_address_i(node_addr), .tx_data_i(tx_data),
    .tx_write_i(tx_write), .tx_holding_empty_o(tx_empty),
    .rx_data_o(rx_data), .rx_ninth_bit_o(rx_ninth),
    .rx_new_frame_o(rx_nf), .rx_byte_available_o(rx_avail),
    .rx_read_i(rx_read), .err_clear_i(err_clear), .framing_err_o(fe),
    .parity_err_o(pe), .overrun_err_o(oe), .break_det_o(brk),
    .tx_irq_o(tx_irq), .rx_irq_o(rx_irq), .timer_expired_o(tmr_exp),
    .rxd_i(rxd), .cts_n_i(cts_n), .txd_o(txd),
    .driver_enable_out_o(de));

  uart_remote_model #(.BT(16)) remote (
    .ref_clk_i(ref_clk_i), .txd_i(txd), .de_i(de),
    .rxd_o(rxd), .cts_n_o(cts_n));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic finish_test;
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [11:0] g, input logic [11:0] e,
                       input string msg);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, g, e);
    end
  endtask

  // holding register may still be busy from the previous byte
  task automatic write_byte(input logic [7:0] b, input logic nbit);
    int k = 0;
    while (tx_empty !== 1'b1 && k < 2000) begin
      @(negedge ref_clk_i);
      k++;
    end
    check(tx_empty, 1'b1, "holding busy");
    tx_data = b;
    ninth = nbit;
    tx_write = 1'b1;
    @(negedge ref_clk_i);
    tx_write = 1'b0;
  endtask

  task automatic read_byte(input logic [9:0] e, input logic [9:0] m,
                           input string msg);
    int k = 0;
    while (rx_avail !== 1'b1 && k < 400) begin
      @(negedge ref_clk_i);
      k++;
    end
    check(rx_avail, 1'b1, "no byte");
    check({rx_nf, rx_ninth, rx_data} & m, e, msg);
    rx_read = 1'b1;
    @(negedge ref_clk_i);
    rx_read = 1'b0;
    @(negedge ref_clk_i);
  endtask

  task automatic drain(output int cnt);
    cnt = 0;
    repeat (2) @(negedge ref_clk_i);
    while (rx_avail === 1'b1 && cnt < 40) begin
      rx_read = 1'b1;
      @(negedge ref_clk_i);
      rx_read = 1'b0;
      @(negedge ref_clk_i);
      cnt++;
    end
  endtask

  task automatic clear_errs;
    err_clear = 1'b1;
    @(negedge ref_clk_i);
    err_clear = 1'b0;
    @(negedge ref_clk_i);
    check({fe, pe, oe, brk}, 4'h0, "errors kept");
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    failures++;
    $display("ERROR %0t timeout", $time);
    finish_test();
  end

  initial begin
    {rst_n_i, timer_mode, par_on, par_odd, two_stop, flow_en} = '0;
    {mn_en, ninth, tx_write, rx_read, err_clear, scheme} = '0;
    {tx_en, rx_en} = 2'b11;
    divisor = 16'h0001;
    node_addr = 8'h42;
    tx_data = 8'h00;
    repeat (4) @(negedge ref_clk_i);
    check({txd, de, tx_empty, rx_avail}, 4'hA, "reset");
    rst_n_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check(tx_irq, 1'b1, "tx irq idle");
    // both directions at once, five formats
    for (int c = 0; c < 5; c++) begin
      d = dtab[c];
      par_on = (c == 1 || c == 2 || c == 4);
      par_odd = (c == 2);
      two_stop = (c == 2);
      mn_en = (c >= 3);
      nv = mn_en ? (c == 3) : (^d ^ par_odd);
      nb = (par_on || mn_en) ? 9 : 8;
      ns = two_stop ? 2 : 1;
      fork
        write_byte(d, nv);
        remote.recv(nb, ns, got, ok);
        remote.send({nv, d}, nb, ns, 1'b1);
      join
      check({ok, got}, {1'b1, (nb == 9) & nv, d}, "tx");
      read_byte({1'b0, mn_en & nv, d}, mn_en ? 10'h1FF : 10'h0FF, "rx");
      check({fe, pe}, 2'b00, "rx err");
    end
    {par_on, par_odd, two_stop, mn_en} = '0;
    // back to back: second byte waits in holding, driver stays on
    fork
      begin
        write_byte(8'h11, 1'b0);
        write_byte(8'h22, 1'b0);
        repeat (4) @(negedge ref_clk_i);
        check(tx_empty, 1'b0, "holding full");
      end
      begin
        remote.recv(8, 1, got, ok);
        check({ok, got}, 10'h211, "first");
        remote.recv(8, 1, got, ok);
        check({ok, got}, 10'h222, "second");
      end
    join
    repeat (40) @(negedge ref_clk_i);
    check({de, txd}, 2'b01, "line idle");
    // flow gate
    flow_en = 1'b1;
    remote.cts_n_o = 1'b1;
    write_byte(8'h5C, 1'b0);
    repeat (200) @(negedge ref_clk_i);
    check({de, txd}, 2'b01, "held by cts");
    remote.cts_n_o = 1'b0;
    remote.recv(8, 1, got, ok);
    check({ok, got}, 10'h25C, "after cts");
    write_byte(8'hC3, 1'b0);
    fork
      remote.recv(8, 1, got, ok);
      begin
        repeat (40) @(negedge ref_clk_i);
        remote.cts_n_o = 1'b1;
      end
    join
    check({ok, got}, 10'h2C3, "cts mid char");
    flow_en = 1'b0;
    write_byte(8'h3A, 1'b0);
    remote.recv(8, 1, got, ok);
    check({ok, got}, 10'h23A, "cts ignored");
    remote.cts_n_o = 1'b0;
    // enables apart
    tx_en = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check(tx_irq, 1'b0, "tx irq off");
    write_byte(8'h77, 1'b0);
    remote.send(9'h0E1, 8, 1, 1'b1);
    read_byte(10'h0E1, 10'h0FF, "rx while tx off");
    check({de, txd}, 2'b01, "tx off");
    tx_en = 1'b1;
    remote.recv(8, 1, got, ok);
    check({ok, got}, 10'h277, "tx on");
    repeat (20) @(negedge ref_clk_i);
    check(tx_irq, 1'b1, "tx irq empty");
    rx_en = 1'b0;
    remote.send(9'h055, 8, 1, 1'b1);
    repeat (20) @(negedge ref_clk_i);
    check(rx_avail, 1'b0, "rx off");
    rx_en = 1'b1;
    // receive faults
    par_on = 1'b1;
    remote.send({~^8'h6B, 8'h6B}, 9, 1, 1'b1);
    repeat (20) @(negedge ref_clk_i);
    check({pe, rx_irq}, 2'b11, "parity");
    par_on = 1'b0;
    drain(n);
    clear_errs();
    remote.send(9'h055, 8, 1, 1'b0);
    repeat (20) @(negedge ref_clk_i);
    check({fe, brk}, 2'b10, "framing");
    drain(n);
    clear_errs();
    remote.send(9'h000, 8, 1, 1'b0);
    drain(n);
    check({brk, fe, 10'(n)}, 12'hC00, "break");
    clear_errs();
    // fill the receive fifo past its depth
    for (int i = 0; i < 33; i++)
      remote.send(9'(i), 8, 1, 1'b1);
    repeat (20) @(negedge ref_clk_i);
    check({oe, rx_irq}, 2'b11, "overrun");
    read_byte(10'h000, 10'h0FF, "fifo head");
    drain(n);
    check(12'(n), 12'h01F, "fifo count");
    check(rx_avail, 1'b0, "fifo empty");
    clear_errs();
    // multinode receive schemes
    mn_en = 1'b1;
    for (int s = 0; s < 4; s++) begin
      scheme = s[1:0];
      remote.send(9'h142, 9, 1, 1'b1);
      remote.send(9'h010, 9, 1, 1'b1);
      remote.send(9'h143, 9, 1, 1'b1);
      remote.send(9'h011, 9, 1, 1'b1);
      if (s == 3)
        read_byte(10'h210, 10'h3FF, "new frame");
      drain(n);
      check(12'(n), 12'((s == 3) ? 0 : cnt_tab[s]), "scheme");
    end
    mn_en = 1'b0;
    // divider as plain timer
    timer_mode = 1'b1;
    divisor = 16'h000A;
    repeat (30) @(negedge ref_clk_i);
    n = 0;
    repeat (100) begin
      @(negedge ref_clk_i);
      if (tmr_exp === 1'b1)
        n++;
    end
    check(12'(n), 12'h00A, "timer");
    finish_test();
  end
endmodule
`default_nettype wire
